// ---- design/srv_pkg.sv ----
/*
  Package for the servo ramp, speed flag and holding brake block: register
  indices, reset values, field positions, limits and timing constants.
  Assumes a single 200 MHz clock and APB access with 32-bit data.
*/
// What this block does
// - stop mode 0 dynamic brake, 1 coast, 2 dynamic brake then coast.
// - limit alarms decelerate with own limit time; 1 ms stops instantly.
// - accel time ms from zero to rated speed, 1..65500, default 200.
// - decel time ms from rated speed to zero, 1..65500.
// - zero s-curve time disables only smoothing; ramp times still act.
// - analog speed source clamps ramp times to 20000, s-curve to 10000.
// - total ramp durations are ramp time plus s-curve time.
// - s-curve time smooths ramps, 0..65500 ms, default 0.
// - zero speed flag while speed at or below range, 0.1 rpm units.
// - target speed flag while absolute speed at or above setting.
// - analog speed equals voltage times full scale over ten volts.
// - analog torque percent equals voltage times full scale over ten.
// - speed scale gives a command in speed mode, limit in torque mode.
// - torque scale gives a command in torque mode, limit otherwise.
// - brake release output rises on-delay ms after enable.
// - brake release output falls off-delay ms after disable, signed; the code treats a negative value as zero on any disable.
// - stop mode applies on servo off, drive alarm and operational stop, not on limit alarms.
// - speed inside zero range before off-delay expiry engages brake now.
// - off-delay expiry engages brake whatever the speed.
// - alarm or operational stop treats negative off-delay as zero.
`default_nettype none
package srv_pkg;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_ACCEL = 16'h0144;
  localparam logic [15:0] IDX_DECEL = 16'h0146;
  localparam logic [15:0] IDX_SCURVE = 16'h0148;
  localparam logic [15:0] IDX_INERTIA = 16'h014A;
  localparam logic [15:0] IDX_ZERO_SPEED_FLAG = 16'h014C;
  localparam logic [15:0] IDX_TARGET_SPEED_FLAG = 16'h014E;
  localparam logic [15:0] IDX_VSCALE = 16'h0150;
  localparam logic [15:0] IDX_TSCALE = 16'h0152;
  localparam logic [15:0] IDX_BRK_ON = 16'h0154;
  localparam logic [15:0] IDX_BRK_OFF = 16'h0156;
  localparam logic [15:0] IDX_CTRL = 16'h0170;
  localparam logic [15:0] IDX_LIM_DEC = 16'h0171;
  localparam logic [15:0] IDX_SPD_SET = 16'h0172;
  localparam logic [15:0] IDX_STATUS = 16'h0173;
  // reset values
  localparam logic [15:0] RST_ACCEL = 16'h00C8;
  localparam logic [15:0] RST_DECEL = 16'h00C8;
  localparam logic [15:0] RST_SCURVE = 16'h0000;
  localparam logic [15:0] RST_INERTIA = 16'h000A;
  localparam logic [15:0] RST_ZERO_SPEED_FLAG = 16'h0064;
  localparam logic [15:0] RST_TARGET_SPEED_FLAG = 16'h0BB8;
  localparam logic [15:0] RST_VSCALE = 16'h2711;
  localparam logic [15:0] RST_TSCALE = 16'h0064;
  localparam logic [15:0] RST_BRK = 16'h0000;
  localparam logic [15:0] RST_LIM_DEC = 16'h0001;
  // control field positions
  localparam int CTRL_SERVO_ON = 0;
  localparam int CTRL_ANALOG = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_STOP_LO = 4;
  // limits
  localparam logic [15:0] ANA_RAMP_MAX = 16'h4E20;   // 20000 ms
  localparam logic [15:0] ANA_SCURVE_MAX = 16'h2710; // 10000 ms
  localparam logic [15:0] FULL_SCALE_MV = 16'h2710;  // 10 V in mV
  localparam logic [15:0] INSTANT_MS = 16'h0001;
  localparam int ZERO_SPEED_FLAG_PER_RPM = 10;                   // 0.1 rpm units
  localparam int FRAC_BITS = 16;
  // timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int TICK_TIME_PS = 1000000000;           // 1 ms
  localparam int TICK_CYCLES = TICK_TIME_PS / CLK_PERIOD_PS;
  typedef enum logic [1:0] {
    SRV_POS_PT, SRV_POS_PR, SRV_SPEED, SRV_TORQUE
  } srv_mode_type;
  typedef enum logic [1:0] {
    SRV_STOP_DYN, SRV_STOP_COAST, SRV_STOP_DYN_COAST, SRV_STOP_RSVD
  } srv_stop_type;
  typedef struct packed {
    logic [1:0] stop_mode;
    logic [1:0] ctrl_mode;
    logic analog_src;
    logic servo_on;
  } srv_ctrl_type;
  typedef struct packed {
    logic enabled;
    logic coast;
    logic dyn_brake;
    logic brake_release;
    logic target_speed_flag;
    logic zero_speed_flag;
  } srv_stat_type;
endpackage : srv_pkg
`default_nettype wire

// ---- design/srv_ramp_brake.sv ----
/*
  Speed ramp generator with s-curve smoothing, zero and target speed flags,
  analog command scaling, stop mode selection and holding brake timing.
  Assumes an APB master on ref_clk, motor speed and analog input from
  logic on the same clock, and alarm pins from outside the clock domain.
*/
`default_nettype none
module srv_ramp_brake
  import srv_pkg::*;
#(
  parameter int TICK_CYC = srv_pkg::TICK_CYCLES, // cycles per ms tick
  parameter int RATED_RPM = 3000                 // rated motor speed
) (
  input wire logic ref_clk,                  // system clock
  input wire logic rst_n,                    // async reset, low active
  input wire logic clk_en,                   // freezes all state when low
  input wire logic psel,                     // apb select
  input wire logic penable,                  // apb enable
  input wire logic pwrite,                   // apb direction
  input wire logic [31:0] paddr,             // apb byte address
  input wire logic [31:0] pwdata,            // apb write data
  output logic [31:0] prdata,                // apb read data
  output logic pready,                       // apb ready
  output logic pslverr,                      // apb error, unmapped
  input wire logic signed [15:0] motor_rpm,  // measured speed, rpm
  input wire logic signed [15:0] analog_mv,  // analog input, mV
  input wire logic alarm_pin,                // drive alarm
  input wire logic op_stop_pin,              // operational stop
  input wire logic rev_limit_pin,            // reverse limit alarm
  input wire logic fwd_limit_pin,            // forward limit alarm
  output logic signed [15:0] speed_cmd,      // ramped speed, rpm
  output logic signed [15:0] ana_speed,      // scaled analog speed
  output logic ana_speed_is_limit,           // ana_speed is a limit
  output logic signed [15:0] ana_torque,     // scaled analog torque %
  output logic ana_torque_is_limit,          // ana_torque is a limit
  output srv_pkg::srv_stat_type stat         // flags and brake outputs
);
  import srv_pkg::*;

  // ****************************************
  // register file
  // ****************************************
  logic [15:0] accel_q, decel_q, scurve_q, inertia_q, zero_speed_flag_q, target_speed_flag_q;
  logic [15:0] vscale_q, tscale_q, brk_on_q, brk_off_q, lim_dec_q;
  logic signed [15:0] spd_set_q;
  srv_ctrl_type ctrl_q;
  srv_stat_type stat_q;
  logic [15:0] idx;
  logic acc_ok, wr_en;
  logic signed [31:0] cmd_q;

  assign idx = paddr[17:2];
  assign acc_ok = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'h0);
  assign wr_en = psel && penable && pwrite && clk_en;
  assign pready = 1'b1;

  // decode a mapped index
  function automatic logic mapped(input logic [15:0] i);
    case (i)
      IDX_ACCEL, IDX_DECEL, IDX_SCURVE, IDX_INERTIA, IDX_ZERO_SPEED_FLAG, IDX_TARGET_SPEED_FLAG,
      IDX_VSCALE, IDX_TSCALE, IDX_BRK_ON, IDX_BRK_OFF, IDX_CTRL,
      IDX_LIM_DEC, IDX_SPD_SET, IDX_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  // error answer for unmapped or misaligned access
  assign pslverr = psel && penable && !(acc_ok && mapped(idx));

  // software writes, zero wait state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      accel_q <= RST_ACCEL;
      decel_q <= RST_DECEL;
      scurve_q <= RST_SCURVE;
      inertia_q <= RST_INERTIA;
      zero_speed_flag_q <= RST_ZERO_SPEED_FLAG;
      target_speed_flag_q <= RST_TARGET_SPEED_FLAG;
      vscale_q <= RST_VSCALE;
      tscale_q <= RST_TSCALE;
      brk_on_q <= RST_BRK;
      brk_off_q <= RST_BRK;
      lim_dec_q <= RST_LIM_DEC;
      spd_set_q <= '0;
      ctrl_q <= '0;
    end else if (wr_en && acc_ok) begin
      case (idx)
        IDX_ACCEL: accel_q <= pwdata[15:0];
        IDX_DECEL: decel_q <= pwdata[15:0];
        IDX_SCURVE: scurve_q <= pwdata[15:0];
        IDX_INERTIA: inertia_q <= pwdata[15:0];
        IDX_ZERO_SPEED_FLAG: zero_speed_flag_q <= pwdata[15:0];
        IDX_TARGET_SPEED_FLAG: target_speed_flag_q <= pwdata[15:0];
        IDX_VSCALE: vscale_q <= pwdata[15:0];
        IDX_TSCALE: tscale_q <= pwdata[15:0];
        IDX_BRK_ON: brk_on_q <= pwdata[15:0];
        IDX_BRK_OFF: brk_off_q <= pwdata[15:0];
        IDX_LIM_DEC: lim_dec_q <= pwdata[15:0];
        IDX_SPD_SET: spd_set_q <= pwdata[15:0];
        IDX_CTRL: ctrl_q <= pwdata[CTRL_STOP_LO+1:0];
        default: ;
      endcase
    end
  end

  // read mux, reserved bits read zero
  always_comb begin
    prdata = '0;
    if (acc_ok) begin
      case (idx)
        IDX_ACCEL: prdata[15:0] = accel_q;
        IDX_DECEL: prdata[15:0] = decel_q;
        IDX_SCURVE: prdata[15:0] = scurve_q;
        IDX_INERTIA: prdata[15:0] = inertia_q;
        IDX_ZERO_SPEED_FLAG: prdata[15:0] = zero_speed_flag_q;
        IDX_TARGET_SPEED_FLAG: prdata[15:0] = target_speed_flag_q;
        IDX_VSCALE: prdata[15:0] = vscale_q;
        IDX_TSCALE: prdata[15:0] = tscale_q;
        IDX_BRK_ON: prdata[15:0] = brk_on_q;
        IDX_BRK_OFF: prdata[15:0] = brk_off_q;
        IDX_LIM_DEC: prdata[15:0] = lim_dec_q;
        IDX_SPD_SET: prdata[15:0] = spd_set_q;
        IDX_CTRL: prdata[CTRL_STOP_LO+1:0] = ctrl_q;
        IDX_STATUS: prdata = {cmd_q[31:16], 10'h000, stat_q};
        default: prdata = '0;
      endcase
    end
  end

  // ****************************************
  // pin synchronisers and ms tick
  // ****************************************
  logic [3:0] s1_q, s2_q, s3_q, pins_q;
  logic [31:0] tick_cnt_q;
  logic tick;

  // three stages; a bit changes once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pins_q <= '0;
    end else if (clk_en) begin
      s1_q <= {fwd_limit_pin, rev_limit_pin, op_stop_pin, alarm_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pins_q <= (s2_q & s3_q) | (pins_q & (s2_q ^ s3_q));
    end
  end

  // millisecond tick divider
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
    end else if (clk_en) begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h0000_0001;
    end
  end
  assign tick = clk_en && (tick_cnt_q == 32'(TICK_CYC - 1));

  logic alarm_stop, limit_hit, drv_en;
  assign alarm_stop = pins_q[0] || pins_q[1];
  assign limit_hit = pins_q[2] || pins_q[3];
  assign drv_en = ctrl_q.servo_on && !alarm_stop;

  // ****************************************
  // analog scaling
  // ****************************************
  logic signed [35:0] ana_spd_w, ana_trq_w;
  srv_mode_type mode;
  assign mode = srv_mode_type'(ctrl_q.ctrl_mode);

  // value = volts * full scale / 10 V
  assign ana_spd_w = (36'(analog_mv) * $signed({1'b0, vscale_q}))
                     / $signed({20'h00000, FULL_SCALE_MV});
  assign ana_trq_w = (36'(analog_mv) * $signed({1'b0, tscale_q}))
                     / $signed({20'h00000, FULL_SCALE_MV});

  // command or limit by control mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ana_speed <= '0;
      ana_torque <= '0;
      ana_speed_is_limit <= 1'b0;
      ana_torque_is_limit <= 1'b1;
    end else if (clk_en) begin
      ana_speed <= ana_spd_w[15:0];
      ana_torque <= ana_trq_w[15:0];
      ana_speed_is_limit <= (mode == SRV_TORQUE);
      ana_torque_is_limit <= (mode != SRV_TORQUE);
    end
  end

  // ****************************************
  // ramp generator
  // ****************************************
  logic [15:0] acc_eff, dec_eff, sc_eff, time_act;
  logic signed [31:0] tgt_fx, err, rate_q, step_max, jerk, rate_n;
  logic accelerating;

  // clamp ramp and s-curve times under analog source
  always_comb begin
    acc_eff = accel_q;
    dec_eff = decel_q;
    sc_eff = scurve_q;
    if (ctrl_q.analog_src) begin
      if (accel_q > ANA_RAMP_MAX) acc_eff = ANA_RAMP_MAX;
      if (decel_q > ANA_RAMP_MAX) dec_eff = ANA_RAMP_MAX;
      if (scurve_q > ANA_SCURVE_MAX) sc_eff = ANA_SCURVE_MAX;
    end
  end

  // target: zero on limit alarm or while disabled, else analog or register speed
  assign tgt_fx = (limit_hit || !drv_en) ? 32'sh0 :
                  (ctrl_q.analog_src ? {ana_speed, 16'h0000}
                                     : {spd_set_q, 16'h0000});
  assign err = tgt_fx - cmd_q;
  assign accelerating = (tgt_fx >= 0) ? (cmd_q >= 0 && err > 0)
                                      : (cmd_q <= 0 && err < 0);
  // limit, accel or decel time; zero treated as one ms
  assign time_act = limit_hit ? lim_dec_q
                    : (accelerating ? acc_eff : dec_eff);
  assign step_max = (32'(RATED_RPM) <<< FRAC_BITS)
                    / $signed({16'h0000, (time_act == 16'h0000)
                                         ? INSTANT_MS : time_act});
  // jerk builds the step over twice the s-curve time, so the
  // abrupt landing still gives a total of ramp time plus s-curve time
  assign jerk = (sc_eff == 16'h0000) ? step_max
                : step_max / $signed({15'h0000, sc_eff, 1'b0});
  // step grows by jerk each tick up to the full step
  assign rate_n = (rate_q + jerk > step_max) ? step_max : rate_q + jerk;

  // one step per ms tick toward the target
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_q <= '0;
      rate_q <= '0;
    end else if (tick) begin
      if (limit_hit && lim_dec_q == INSTANT_MS) begin
        cmd_q <= '0;
        rate_q <= '0;
      end else if ((err >= 0 ? err : -err) <= rate_n) begin
        cmd_q <= tgt_fx;
        rate_q <= '0;
      end else begin
        cmd_q <= (err > 0) ? cmd_q + rate_n : cmd_q - rate_n;
        rate_q <= rate_n;
      end
    end
  end
  assign speed_cmd = cmd_q[31:16];

  // ****************************************
  // speed flags
  // ****************************************
  logic [16:0] abs_rpm;
  logic [20:0] abs_dec;
  assign abs_rpm = (motor_rpm < 0) ? 17'(-33'(motor_rpm))
                                   : 17'(motor_rpm);
  assign abs_dec = 21'(abs_rpm * 21'(ZERO_SPEED_FLAG_PER_RPM));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q.zero_speed_flag <= 1'b1;
      stat_q.target_speed_flag <= 1'b0;
    end else if (clk_en) begin
      stat_q.zero_speed_flag <= (abs_dec <= {5'h00, zero_speed_flag_q});
      stat_q.target_speed_flag <= (abs_rpm >= {1'b0, target_speed_flag_q});
    end
  end

  // ****************************************
  // stop mode
  // ****************************************
  srv_stop_type stop;
  assign stop = srv_stop_type'(ctrl_q.stop_mode);

  // braking method once disabled or alarmed
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q.dyn_brake <= 1'b0;
      stat_q.coast <= 1'b1;
      stat_q.enabled <= 1'b0;
    end else if (clk_en) begin
      stat_q.enabled <= drv_en;
      if (drv_en) begin
        stat_q.dyn_brake <= 1'b0;
        stat_q.coast <= 1'b0;
      end else begin
        case (stop)
          SRV_STOP_DYN: begin
            stat_q.dyn_brake <= 1'b1;
            stat_q.coast <= 1'b0;
          end
          SRV_STOP_COAST: begin
            stat_q.dyn_brake <= 1'b0;
            stat_q.coast <= 1'b1;
          end
          SRV_STOP_DYN_COAST: begin
            stat_q.dyn_brake <= !stat_q.zero_speed_flag;
            stat_q.coast <= stat_q.zero_speed_flag;
          end
          default: begin
            stat_q.dyn_brake <= 1'b1;
            stat_q.coast <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // holding brake timing
  // ****************************************
  logic [15:0] brk_cnt_q, off_eff;
  logic en_prev_q;
  assign off_eff = brk_off_q[15] ? 16'h0000 : brk_off_q;

  // whole ms counted from each enable or disable edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      brk_cnt_q <= '0;
      en_prev_q <= 1'b0;
      stat_q.brake_release <= 1'b0;
    end else if (clk_en) begin
      en_prev_q <= drv_en;
      if (drv_en != en_prev_q) begin
        brk_cnt_q <= '0;
      end else if (tick) begin
        if (drv_en && !stat_q.brake_release) begin
          if (brk_cnt_q >= brk_on_q) stat_q.brake_release <= 1'b1;
          else brk_cnt_q <= brk_cnt_q + 16'h0001;
        end else if (!drv_en && stat_q.brake_release) begin
          if (brk_cnt_q >= off_eff || stat_q.zero_speed_flag)
            stat_q.brake_release <= 1'b0;
          else brk_cnt_q <= brk_cnt_q + 16'h0001;
        end
      end
    end
  end
  assign stat = stat_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_off_at_zero;
    !drv_en && !en_prev_q && stat_q.brake_release
      && stat_q.zero_speed_flag && tick;
  endsequence

  chk_stop_instant: assert property (
    tick && limit_hit && lim_dec_q == INSTANT_MS |=> cmd_q == 0)
    else $error("limit stop not instant");
  chk_zero_flag: assert property (
    clk_en |=> stat_q.zero_speed_flag
      == ($past(abs_dec) <= {5'h00, $past(zero_speed_flag_q)}))
    else $error("zero speed flag wrong");
  chk_target_flag: assert property (
    clk_en && abs_rpm < {1'b0, target_speed_flag_q} |=> !stat_q.target_speed_flag)
    else $error("target flag stays high");
  chk_coast_mode: assert property (
    clk_en && !drv_en && stop == SRV_STOP_COAST
      |=> stat_q.coast && !stat_q.dyn_brake)
    else $error("coast mode wrong");
  chk_dyn_then_coast: assert property (
    clk_en && !drv_en && stop == SRV_STOP_DYN_COAST
      && !stat_q.zero_speed_flag |=> stat_q.dyn_brake)
    else $error("dynamic brake missing");
  chk_release_cause: assert property (
    $rose(stat_q.brake_release) |-> $past(drv_en) && $past(tick))
    else $error("brake released without enable");
  chk_brake_zero_spd: assert property (
    s_off_at_zero |=> !stat_q.brake_release)
    else $error("brake not engaged at zero speed");
  chk_analog_clamp: assert property (
    ctrl_q.analog_src |-> acc_eff <= ANA_RAMP_MAX
      && dec_eff <= ANA_RAMP_MAX && sc_eff <= ANA_SCURVE_MAX)
    else $error("analog ramp clamp missing");
  chk_off_delay_zero: assert property (
    !drv_en && !en_prev_q && stat_q.brake_release && tick
      && off_eff == 0 |=> !stat_q.brake_release)
    else $error("zero off delay not on next tick");
endmodule : srv_ramp_brake
`default_nettype wire

// ---- tb/srv_motor_model.sv ----
/*
  Motor model for the ramp and brake bench: measured speed follows the
  drive command while enabled and spins down otherwise.
  Assumes drive outputs and the bench override on ref_clk.
*/
`default_nettype none
module srv_motor_model
  import srv_pkg::*;
(
  input wire logic ref_clk,                 // system clock
  input wire logic ovr_en,                  // bench forces the speed
  input wire logic signed [15:0] ovr_rpm,   // forced speed, rpm
  input wire logic signed [15:0] speed_cmd, // drive speed command
  input wire srv_pkg::srv_stat_type stat,   // drive flags
  output logic signed [15:0] motor_rpm      // measured speed, rpm
);
  timeunit 1ns;
  timeprecision 1ps;
  // speed follows command, forced value, or halves when disabled
  always_ff @(posedge ref_clk) begin
    if (ovr_en) motor_rpm <= ovr_rpm;
    else if (stat.enabled) motor_rpm <= speed_cmd;
    else motor_rpm <= motor_rpm >>> 1;
  end
endmodule : srv_motor_model
`default_nettype wire

// ---- tb/srv_ramp_brake_tb.sv ----
/*
  Bench for srv_ramp_brake: registers, analog scaling, speed flags,
  ramps, brake timing, stop modes and limit stops.
  Assumes srv_pkg and the motor model; tick shortened to 10 cycles.
*/
`default_nettype none
module srv_ramp_brake_tb;
  import srv_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 10;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic alarm_pin, op_stop_pin, rev_limit_pin, fwd_limit_pin, ovr_en;
  logic clk_en;
  logic ana_speed_is_limit, ana_torque_is_limit;
  logic signed [15:0] motor_rpm, analog_mv, ovr_rpm;
  logic signed [15:0] speed_cmd, ana_speed, ana_torque;
  srv_stat_type stat;
  int errors, checked, n;
  srv_ramp_brake #(.TICK_CYC(T)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_rpm(motor_rpm), .analog_mv(analog_mv), .alarm_pin(alarm_pin),
    .op_stop_pin(op_stop_pin), .rev_limit_pin(rev_limit_pin),
    .fwd_limit_pin(fwd_limit_pin), .speed_cmd(speed_cmd),
    .ana_speed(ana_speed), .ana_speed_is_limit(ana_speed_is_limit),
    .ana_torque(ana_torque), .ana_torque_is_limit(ana_torque_is_limit),
    .stat(stat));
  srv_motor_model u_motor (.ref_clk(ref_clk), .ovr_en(ovr_en),
    .ovr_rpm(ovr_rpm), .speed_cmd(speed_cmd), .stat(stat),
    .motor_rpm(motor_rpm));
  // clock of 5 ns
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic close_out;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rng(input int lo, input int hi);
    checked++;
    if (n < lo || n > hi) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h..%h", $time, n,
               lo, hi);
    end
  endtask : rng
  task automatic apb(input logic w, input logic [15:0] ix,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {14'h0, ix, 2'h0};
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic wr(input logic [15:0] ix, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, ix, d, r, e);
  endtask : wr
  task automatic rd(input logic [15:0] ix, input logic [31:0] x,
                    input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'h0, ix, 32'h0, r, e);
    chk(r, x);
    chk(e, xe);
  endtask : rd
  // wait for speed_cmd (k 0) or brake release (k 1), cycles into n
  task automatic wt(input int k, input logic [15:0] v);
    n = 0;
    while (((k == 1) ? {15'h0, stat.brake_release} : speed_cmd) !== v
           && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time,
               ((k == 1) ? {15'h0, stat.brake_release} : speed_cmd), v);
    end
  endtask : wt
  task automatic setm(input logic en, input logic [15:0] v);
    @(posedge ref_clk);
    ovr_en <= en;
    ovr_rpm <= v;
    repeat (4) @(posedge ref_clk);
  endtask : setm
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    logic [15:0] ix [7] = '{IDX_ACCEL, IDX_SCURVE, IDX_TARGET_SPEED_FLAG, IDX_VSCALE,
                            IDX_TSCALE, IDX_BRK_ON, IDX_BRK_OFF};
    logic [15:0] rv [7] = '{RST_ACCEL, RST_SCURVE, RST_TARGET_SPEED_FLAG, RST_VSCALE,
                            RST_TSCALE, RST_BRK, RST_BRK};
    for (int i = 0; i < 7; i++) begin
      rd(ix[i], {16'h0, rv[i]}, 1'h0);
    end
    wr(IDX_ACCEL, 32'h0000FFDC);
    rd(IDX_ACCEL, 32'h0000FFDC, 1'h0);
    clk_en <= 1'h0;
    wr(IDX_DECEL, 32'h0123);
    clk_en <= 1'h1;
    rd(IDX_DECEL, {16'h0, RST_DECEL}, 1'h0);
    rd(16'h0100, 32'h0, 1'h1);
    $display("test regs done");
  endtask : t_regs
  task automatic t_scale;
    wr(IDX_CTRL, 32'h08);
    wr(IDX_VSCALE, 32'h0BB8);
    wr(IDX_TSCALE, 32'h64);
    @(posedge ref_clk);
    analog_mv <= 16'sh1388;
    repeat (4) @(posedge ref_clk);
    chk({16'h0, ana_speed}, 32'h05DC);
    chk({16'h0, ana_torque}, 32'h0032);
    chk(ana_speed_is_limit, 1'h0);
    chk(ana_torque_is_limit, 1'h1);
    wr(IDX_CTRL, 32'h0C);
    analog_mv <= 16'shD8F0;
    repeat (4) @(posedge ref_clk);
    chk({16'h0, ana_speed}, 32'hF448);
    chk({16'h0, ana_torque}, 32'hFF9C);
    chk(ana_speed_is_limit, 1'h1);
    chk(ana_torque_is_limit, 1'h0);
    $display("test scale done");
  endtask : t_scale
  task automatic t_flags;
    wr(IDX_CTRL, 32'h08);
    setm(1'h1, 16'h000A);
    chk(stat.zero_speed_flag, 1'h1);
    setm(1'h1, 16'h000B);
    chk(stat.zero_speed_flag, 1'h0);
    setm(1'h1, 16'hF448);
    chk(stat.target_speed_flag, 1'h1);
    setm(1'h1, 16'h0BB7);
    chk(stat.target_speed_flag, 1'h0);
    $display("test flags done");
  endtask : t_flags
  task automatic t_ramp;
    setm(1'h0, 16'h0);
    wr(IDX_ACCEL, 32'h0A);
    wr(IDX_DECEL, 32'h0A);
    wr(IDX_SPD_SET, 32'h0BB8);
    wr(IDX_CTRL, 32'h09);
    wt(0, 16'h0BB8);
    rng(85, 125);
    rd(IDX_STATUS, 32'h0BB80026, 1'h0);
    wr(IDX_SPD_SET, 32'h0);
    wt(0, 16'h0);
    rng(85, 125);
    wr(IDX_SCURVE, 32'h0A);
    wr(IDX_SPD_SET, 32'h0BB8);
    wt(0, 16'h0BB8);
    rng(175, 235);
    wr(IDX_SCURVE, 32'h0);
    $display("test ramp done");
  endtask : t_ramp
  task automatic t_brake;
    wr(IDX_CTRL, 32'h08);
    wt(1, 16'h0);
    rng(1, 20);
    chk(stat.dyn_brake, 1'h1);
    wr(IDX_BRK_ON, 32'h05);
    wr(IDX_CTRL, 32'h09);
    wt(1, 16'h1);
    rng(45, 75);
    wr(IDX_BRK_OFF, 32'h05);
    setm(1'h1, 16'h03E8);
    alarm_pin <= 1'h1;
    wt(1, 16'h0);
    rng(45, 80);
    chk(stat.dyn_brake, 1'h1);
    wr(IDX_CTRL, 32'h18);
    alarm_pin <= 1'h0;
    wr(IDX_BRK_ON, 32'h0);
    wr(IDX_BRK_OFF, 32'h64);
    wr(IDX_CTRL, 32'h19);
    wt(1, 16'h1);
    rng(1, 20);
    setm(1'h1, 16'h0);
    wr(IDX_CTRL, 32'h18);
    wt(1, 16'h0);
    rng(1, 20);
    chk(stat.coast, 1'h1);
    wr(IDX_BRK_OFF, 32'hFFFB);
    wr(IDX_CTRL, 32'h29);
    setm(1'h1, 16'h03E8);
    wt(1, 16'h1);
    op_stop_pin <= 1'h1;
    wt(1, 16'h0);
    rng(1, 25);
    chk({stat.dyn_brake, stat.coast}, 2'h2);
    setm(1'h1, 16'h0005);
    chk({stat.dyn_brake, stat.coast}, 2'h1);
    op_stop_pin <= 1'h0;
    $display("test brake done");
  endtask : t_brake
  task automatic t_limit;
    setm(1'h0, 16'h0);
    wr(IDX_CTRL, 32'h09);
    wt(0, 16'h0BB8);
    rev_limit_pin <= 1'h1;
    wt(0, 16'h0);
    rng(1, 30);
    rev_limit_pin <= 1'h0;
    wt(0, 16'h0BB8);
    wr(IDX_LIM_DEC, 32'h0A);
    fwd_limit_pin <= 1'h1;
    wt(0, 16'h0);
    rng(85, 130);
    wr(IDX_ACCEL, 32'h7530);
    wr(IDX_CTRL, 32'h0B);
    fwd_limit_pin <= 1'h0;
    wt(0, 16'hFFF1);
    rng(900, 990);
    $display("test limit done");
  endtask : t_limit
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    {rst_n, psel, penable, pwrite, alarm_pin, op_stop_pin} = 6'h0;
    {rev_limit_pin, fwd_limit_pin, ovr_en} = 3'h1;
    clk_en = 1'h1;
    {paddr, pwdata} = 64'h0;
    {analog_mv, ovr_rpm} = 32'h0;
    errors = 0;
    checked = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'h1;
    t_regs();
    t_scale();
    t_flags();
    t_ramp();
    t_brake();
    t_limit();
    close_out();
  end
  initial begin
    #100us;
    errors++;
    close_out();
  end
endmodule : srv_ramp_brake_tb
`default_nettype wire
